// ### fbcsb_pkg.sv
// Shared constants and carrier types for the font, cursor and segment blink block
package fbcsb_pkg;

   // Register port geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;

   // Register offsets
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_WPTR   = 4'h1;
   localparam logic [3:0] REG_TEXT   = 4'h2;
   localparam logic [3:0] REG_INSTR  = 4'h3;
   localparam logic [3:0] REG_UFONT  = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h5;

   // User font write field positions
   localparam int UFONT_GLYPH_BIT = 11;
   localparam int UFONT_ROW_LSB   = 8;
   localparam int UFONT_DOTS      = 5;
   localparam int UFONT_ROWS      = 8;
   localparam int UFONT_GLYPHS    = 2;

   // Instruction codes
   localparam logic [7:0] INSTR_BLINK_SYNC = 8'h70;

   // Display text memory and write pointer
   localparam int         TEXT_DEPTH  = 80;
   localparam int         PTR_W       = 7;
   localparam logic [6:0] PTR_RESET   = 7'h00;
   localparam logic [6:0] PTR_LAST    = 7'h4F;
   localparam logic [6:0] LINE1_LO    = 7'h00;
   localparam logic [6:0] LINE1_HI    = 7'h13;
   localparam logic [6:0] LINE2_LO    = 7'h20;
   localparam logic [6:0] LINE2_HI    = 7'h33;
   localparam logic [6:0] LINE2_BASE  = 7'h20;

   // Blink frame counts per phase
   localparam int         FRAMES_SHORT = 32;
   localparam int         FRAMES_LONG  = 64;
   localparam logic [5:0] BLINK_LAST_SHORT = 6'(FRAMES_SHORT - 1);
   localparam logic [5:0] BLINK_LAST_LONG  = 6'(FRAMES_LONG - 1);

   // Segment drive geometry
   localparam int         SEG_OUTS      = 80;
   localparam int         SEG_BYTES     = 20;
   localparam logic [2:0] PHASES_TWO_ROW = 3'h2;
   localparam logic [2:0] PHASES_ONE_ROW = 3'h3;
   localparam logic [2:0] PHASES_SEG     = 3'h4;

   // Font mapping biases
   localparam logic [7:0] PAGE0_RAM_TOP = 8'h0F;
   localparam logic [8:0] PAGE0_BIAS    = 9'h00F;
   localparam logic [8:0] PAGE1_LO_ADD  = 9'h0D1;
   localparam logic [8:0] PAGE1_HI_ADD  = 9'h0B1;

   // Control register layout, bit 10 first, bit 0 last
   typedef struct packed {
      logic ptr_decrement;
      logic one_row;
      logic character_display_mode;
      logic two_bit_seg_mode;
      logic flash_period_long;
      logic flash;
      logic underline;
      logic reverse;
      logic row_highlight;
      logic first_line_tall;
      logic rom_page;
   } fbcsb_ctrl_s;

   localparam int          CTRL_W     = $bits(fbcsb_ctrl_s);
   localparam fbcsb_ctrl_s CTRL_RESET = '0;

   // Character scan request from the display timing
   typedef struct packed {
      logic       line;
      logic [3:0] col;
      logic [2:0] row;
   } fbcsb_scan_s;

   // Glyph answer for one scanned dot row
   typedef struct packed {
      logic       valid;
      logic       from_ram;
      logic [8:0] rom_index;
      logic [2:0] row;
      logic [4:0] ram_dots;
      logic       reverse;
      logic       underline;
      logic       blank;
   } fbcsb_glyph_s;

   localparam fbcsb_glyph_s GLYPH_RESET = '0;

endpackage

// ### fbcsb_text_ram.sv
// Display text memory: one write port, two registered read ports
`timescale 1ns/1ps
module fbcsb_text_ram #(
   parameter int DEPTH = 80,
   parameter int AW    = 7,
   parameter int DW    = 8
) (
   // Clock
   input  wire logic          clk,
   // Write port
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [DW-1:0] wr_data,
   // Read ports
   input  wire logic [AW-1:0] rd_a_addr,
   output logic      [DW-1:0] rd_a_data,
   input  wire logic [AW-1:0] rd_b_addr,
   output logic      [DW-1:0] rd_b_data
);

   logic [DW-1:0] mem [DEPTH];

   // Storage write
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Registered reads
   always_ff @(posedge clk) begin
      rd_a_data <= mem[rd_a_addr];
      rd_b_data <= mem[rd_b_addr];
   end

endmodule

// ### fbcsb_top.sv
// Font bank mapping, row cursor, segment decode and blink timing
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
// What this block does
// - Page zero maps codes 00-0F to user glyphs, 10-FF to patterns 1-240.
// - Page one maps 00-1F/80-9F to user glyphs, others to patterns 241-432.
// - Exactly two user glyphs, shown identically on both font pages.
// - Tall bit stretches every first-line character to double height.
// - In character display mode, row highlight marks line one for pointer 00-13, line two for 20-33.
// - Highlighted row drawn reversed, underlined or blinking per its bits.
// - Blinking row cursor period follows the long-period control bit.
// - With row highlight clear, no cursor attribute appears.
// - Segments drive 160, 240 or 320 according to display mode.
// - One-bit segment mode uses D7-D4 only, one dark, zero light.
// - Each display text write steps the write pointer up or down.
// - Byte bit positions map to column outputs 4n+1 through 4n+4.
// - Two-bit pairs: 00 light, 01 blink, 10 inverse blink, 11 dark.
// - Each blink phase lasts 32 frames, or 64 with long period.
// - Active phase darkens normal blinkers and lights inverse blinkers.
// - Instruction 70 clears the blink counter and starts an active phase.
module fbcsb_top
   import fbcsb_pkg::*;
(
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     reset_n,
   // Register port
   input  wire logic [ADDR_W-1:0]        reg_addr,
   input  wire logic [DATA_W-1:0]        reg_wdata,
   input  wire logic                     reg_wr,
   input  wire logic                     reg_rd,
   output logic      [DATA_W-1:0]        reg_rdata,
   // Display timing
   input  wire logic                     frame_tick,
   input  wire logic [1:0]               com_phase,
   input  wire logic                     scan_valid,
   input  wire fbcsb_scan_s              scan_req,
   // Glyph answer
   output fbcsb_glyph_s                  glyph,
   // Segment drivers
   output logic      [SEG_OUTS-1:0]      column_driver_output
);

   fbcsb_ctrl_s      ctrl_r;
   logic [PTR_W-1:0] write_pointer_r;
   logic [PTR_W-1:0] write_pointer_nxt;
   logic [5:0]       blink_cnt_r;
   logic             blink_on_r;
   logic [5:0]       blink_last;
   logic             text_wr;
   logic             blink_sync;
   logic [4:0]       ufont_r [UFONT_GLYPHS][UFONT_ROWS];
   logic [7:0]       scan_code;
   logic [7:0]       seg_byte;
   logic [PTR_W-1:0] scan_addr;
   logic [PTR_W-1:0] seg_addr;
   logic             eff_line;
   logic [2:0]       eff_row;
   logic             s1_valid_r;
   logic             s1_line_r;
   logic [2:0]       s1_row_r;
   logic [4:0]       seg_idx_r;
   logic [4:0]       seg_idx_d_r;
   logic [1:0]       seg_phase_d_r;
   logic [2:0]       phases_used;
   logic [SEG_OUTS-1:0] col_r;
   logic             line_hit;
   logic             cursor_on;
   logic [9:0]       code_map;

   // Map a character code to a pattern source and index
   function automatic logic [9:0] map_code(input logic [7:0] code, input logic page);
      logic       ram;
      logic [8:0] idx;
      ram = 1'b0;
      idx = '0;
      if (!page) begin
         ram = (code <= PAGE0_RAM_TOP);
         idx = {1'b0, code} - PAGE0_BIAS;
      end else begin
         ram = (code[6:5] == 2'h0);
         idx = {1'b0, code} + (code[7] ? PAGE1_HI_ADD : PAGE1_LO_ADD);
      end
      map_code = {ram, ram ? 9'h000 : idx};
   endfunction

   // Decode one byte into four column states
   function automatic logic [3:0] seg_decode(input logic [7:0] b, input logic two_bit,
                                             input logic on, input logic active);
      logic [3:0] r;
      logic [1:0] pair;
      r = '0;
      pair = '0;
      for (int k = 0; k < 4; k++) begin
         pair = b[7-2*k -: 2];
         if (!two_bit) begin
            // upper nibble only, one is dark
            r[3-k] = b[7-k];
         end else begin
            unique case (pair)
               2'h0: r[3-k] = 1'b0;
               // normal blinker on in active phase
               2'h1: r[3-k] = on;
               2'h2: r[3-k] = ~on;
               2'h3: r[3-k] = 1'b1;
            endcase
         end
      end
      seg_decode = active ? r : 4'h0;
   endfunction

   assign text_wr    = reg_wr && (reg_addr == REG_TEXT);
   assign blink_sync = reg_wr && (reg_addr == REG_INSTR) && (reg_wdata[7:0] == INSTR_BLINK_SYNC);

   // Control register
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ctrl_r <= CTRL_RESET;
      end else if (reg_wr && reg_addr == REG_CTRL) begin
         ctrl_r <= fbcsb_ctrl_s'(reg_wdata[CTRL_W-1:0]);
      end
   end

   // Pointer step with wrap inside the text memory
   always_comb begin
      write_pointer_nxt = write_pointer_r;
      if (reg_wr && reg_addr == REG_WPTR) begin
         write_pointer_nxt = reg_wdata[PTR_W-1:0];
      end else if (text_wr) begin
         if (ctrl_r.ptr_decrement) begin
            write_pointer_nxt = (write_pointer_r == PTR_RESET) ? PTR_LAST : write_pointer_r - 7'h01;
         end else begin
            write_pointer_nxt = (write_pointer_r >= PTR_LAST) ? PTR_RESET : write_pointer_r + 7'h01;
         end
      end
   end

   // Write pointer register
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         write_pointer_r <= PTR_RESET;
      end else begin
         write_pointer_r <= write_pointer_nxt;
      end
   end

   // User glyph storage, shared by both font pages
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         for (int g = 0; g < UFONT_GLYPHS; g++) begin
            for (int r = 0; r < UFONT_ROWS; r++) begin
               ufont_r[g][r] <= '0;
            end
         end
      end else if (reg_wr && reg_addr == REG_UFONT) begin
         ufont_r[reg_wdata[UFONT_GLYPH_BIT]][reg_wdata[UFONT_ROW_LSB +: 3]] <=
            reg_wdata[UFONT_DOTS-1:0];
      end
   end

   assign blink_last = ctrl_r.flash_period_long ? BLINK_LAST_LONG : BLINK_LAST_SHORT;

   // Shared frame counter and blink phase
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         blink_cnt_r <= '0;
         blink_on_r  <= 1'b0;
      end else if (blink_sync) begin
         blink_cnt_r <= '0;
         blink_on_r  <= 1'b1;
      end else if (frame_tick) begin
         // one counter for cursor and segments
         if (blink_cnt_r >= blink_last) begin
            blink_cnt_r <= '0;
            blink_on_r  <= ~blink_on_r;
         end else begin
            blink_cnt_r <= blink_cnt_r + 6'h01;
         end
      end
   end

   // Register read data, valid the cycle after the strobe
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         unique case (reg_addr)
            REG_CTRL:   reg_rdata <= DATA_W'(ctrl_r);
            REG_WPTR:   reg_rdata <= DATA_W'(write_pointer_r);
            REG_STATUS: reg_rdata <= DATA_W'({blink_on_r, blink_cnt_r});
            default:    reg_rdata <= '0;
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

   // Scan address, first line repeated when tall
   always_comb begin
      eff_line  = ctrl_r.first_line_tall ? 1'b0 : scan_req.line;
      eff_row   = ctrl_r.first_line_tall ? {scan_req.line, scan_req.row[2:1]} : scan_req.row;
      scan_addr = (eff_line ? LINE2_BASE : PTR_RESET) + {3'h0, scan_req.col};
   end

   // Segment byte sweep address
   assign seg_addr = 7'(com_phase) * 7'(SEG_BYTES) + {2'h0, seg_idx_r};

   fbcsb_text_ram #(
      .DEPTH (TEXT_DEPTH),
      .AW    (PTR_W),
      .DW    (8)
   ) i_fbcsb_text_ram (
      .clk       (clk),
      .wr_en     (text_wr),
      .wr_addr   (write_pointer_r),
      .wr_data   (reg_wdata[7:0]),
      .rd_a_addr (scan_addr),
      .rd_a_data (scan_code),
      .rd_b_addr (seg_addr),
      .rd_b_data (seg_byte)
   );

   // Scan stage one, aligned with the memory read
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s1_valid_r <= 1'b0;
         s1_line_r  <= 1'b0;
         s1_row_r   <= '0;
      end else begin
         s1_valid_r <= scan_valid;
         s1_line_r  <= eff_line;
         s1_row_r   <= eff_row;
      end
   end

   // Row cursor qualification
   always_comb begin
      line_hit = (!s1_line_r && write_pointer_r >= LINE1_LO && write_pointer_r <= LINE1_HI) ||
                 (s1_line_r && write_pointer_r >= LINE2_LO && write_pointer_r <= LINE2_HI);
      cursor_on = ctrl_r.character_display_mode && ctrl_r.row_highlight && line_hit;
   end

   // Pattern source of the code just read
   assign code_map = map_code(scan_code, ctrl_r.rom_page);

   // Glyph answer register
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         glyph <= GLYPH_RESET;
      end else begin
         glyph.valid     <= s1_valid_r;
         glyph.from_ram  <= code_map[9];
         glyph.rom_index <= code_map[8:0];
         glyph.row       <= s1_row_r;
         glyph.ram_dots  <= code_map[9] ? ufont_r[scan_code[0]][s1_row_r] : 5'h00;
         glyph.reverse   <= cursor_on && ctrl_r.reverse;
         glyph.underline <= cursor_on && ctrl_r.underline;
         glyph.blank     <= cursor_on && ctrl_r.flash && !blink_on_r;
      end
   end

   // common phases in use per mode
   assign phases_used = !ctrl_r.character_display_mode ? PHASES_SEG :
                        (ctrl_r.one_row ? PHASES_ONE_ROW : PHASES_TWO_ROW);

   // Sweep through the segment bytes of the current phase
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         seg_idx_r     <= '0;
         seg_idx_d_r   <= '0;
         seg_phase_d_r <= '0;
      end else begin
         seg_idx_r     <= (seg_idx_r == 5'(SEG_BYTES - 1)) ? 5'h00 : seg_idx_r + 5'h01;
         seg_idx_d_r   <= seg_idx_r;
         seg_phase_d_r <= com_phase;
      end
   end

   // Column drive latch, four outputs per byte
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         col_r <= '0;
      end else begin
         col_r[{seg_idx_d_r, 2'h0} +: 4] <= seg_decode(seg_byte, ctrl_r.two_bit_seg_mode,
                                                       blink_on_r,
                                                       {1'b0, seg_phase_d_r} < phases_used);
      end
   end

   // Highest data bits sit on the lowest numbered output
   for (genvar i = 0; i < SEG_BYTES; i++) begin : g_seg_order
      for (genvar k = 0; k < 4; k++) begin : g_bit
         assign column_driver_output[4*i+k] = col_r[4*i+3-k];
      end
   end

endmodule

// ### fbcsb_monitor.sv
// Port-level checker for the font, cursor and segment blink block
`timescale 1ns/1ps
module fbcsb_monitor
   import fbcsb_pkg::*;
(
   // Clock and reset
   input wire logic                clk,
   input wire logic                reset_n,
   // Register port
   input wire logic [ADDR_W-1:0]   reg_addr,
   input wire logic [DATA_W-1:0]   reg_wdata,
   input wire logic                reg_wr,
   input wire logic                reg_rd,
   input wire logic [DATA_W-1:0]   reg_rdata,
   // Display side
   input wire logic [1:0]          com_phase,
   input wire fbcsb_glyph_s        glyph,
   input wire logic [SEG_OUTS-1:0] column_driver_output
);
   fbcsb_ctrl_s ctl_r;
   logic [1:0]  com_r;
   logic [4:0]  hold_r;
   wire         settled = hold_r >= 5'h04;
   wire         seg_settled = hold_r == 5'h1F;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // Shadow control word, age since it or the common phase last moved
   always_ff @(posedge clk) begin
      com_r <= com_phase;
      if (!reset_n) begin
         ctl_r  <= CTRL_RESET;
         hold_r <= 5'h00;
      end else if ((reg_wr && reg_addr == REG_CTRL) || com_phase != com_r) begin
         if (reg_wr && reg_addr == REG_CTRL) ctl_r <= fbcsb_ctrl_s'(reg_wdata[CTRL_W-1:0]);
         hold_r <= 5'h00;
      end else if (hold_r != 5'h1F) begin
         hold_r <= hold_r + 5'h01;
      end
   end

   // Expected pointer after one text write
   function automatic logic [6:0] step(input logic [6:0] p, input logic dn);
      if (dn) return (p == PTR_RESET) ? PTR_LAST : p - 7'h01;
      return (p == PTR_LAST) ? PTR_RESET : p + 7'h01;
   endfunction

   sequence s_sync_status;
      reg_wr && reg_addr == REG_INSTR && reg_wdata[7:0] == INSTR_BLINK_SYNC
      ##1 reg_rd && reg_addr == REG_STATUS;
   endsequence
   sequence s_rd_wr_rd;
      reg_rd && reg_addr == REG_WPTR ##1 reg_wr && reg_addr == REG_TEXT
      ##1 reg_rd && reg_addr == REG_WPTR;
   endsequence

   AST_SYNC_RESTART: assert property (s_sync_status |=> reg_rdata == 16'h0040)
      else $error("blink sync did not restart count and phase");
   AST_PTR_STEP: assert property (s_rd_wr_rd |=>
      reg_rdata[6:0] == step(7'($past(reg_rdata, 2)), ctl_r.ptr_decrement))
      else $error("write pointer did not step after a text write");
   AST_NO_CURSOR: assert property (glyph.valid && settled && !ctl_r.row_highlight
      |-> !glyph.reverse && !glyph.underline && !glyph.blank)
      else $error("cursor attribute with row highlight off");
   AST_CURSOR_KIND: assert property (glyph.valid && settled |-> (!glyph.reverse ||
      ctl_r.reverse) && (!glyph.underline || ctl_r.underline) && (!glyph.blank || ctl_r.flash))
      else $error("cursor attribute without its enable");
   AST_PAGE0: assert property (glyph.valid && settled && !ctl_r.rom_page && !glyph.from_ram
      |-> glyph.rom_index inside {[9'h001:9'h0F0]})
      else $error("page zero pattern out of range");
   AST_PAGE1: assert property (glyph.valid && settled && ctl_r.rom_page && !glyph.from_ram
      |-> glyph.rom_index inside {[9'h0F1:9'h1B0]})
      else $error("page one pattern out of range");
   AST_RAM_INDEX: assert property (glyph.valid && glyph.from_ram |-> glyph.rom_index == 9'h000)
      else $error("user glyph answer carries a pattern index");
   AST_SEG_UNUSED: assert property (seg_settled && ctl_r.character_display_mode &&
      !ctl_r.one_row && com_phase[1] |-> column_driver_output == '0)
      else $error("unused common phase drives segments");
endmodule

bind fbcsb_top fbcsb_monitor i_fbcsb_monitor (.clk(clk), .reset_n(reset_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .com_phase(com_phase), .glyph(glyph),
   .column_driver_output(column_driver_output));

// ### fbcsb_host_model.sv
// Host model driving the register port of the block
`timescale 1ns/1ps
module fbcsb_host_model
   import fbcsb_pkg::*;
(
   // Clock
   input  wire logic         clk,
   // Register port
   output logic [ADDR_W-1:0] reg_addr,
   output logic [DATA_W-1:0] reg_wdata,
   output logic              reg_wr,
   output logic              reg_rd
);
   // Quiet port at time zero
   initial begin
      reg_addr  = '0;
      reg_wdata = '0;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
   end

   // One access launched after an edge, taken at the next
   task automatic xfer(input logic w, input logic r, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d);
      reg_wr    <= w;
      reg_rd    <= r;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
   endtask

   task automatic set_ctrl(input fbcsb_ctrl_s c);
      if (c.character_display_mode) c.two_bit_seg_mode = 1'b1;
      xfer(1'b1, 1'b0, REG_CTRL, DATA_W'(c));
   endtask
endmodule

// ### tb_fbcsb_top.sv
// Self-checking bench for the font, cursor and segment blink block
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_fbcsb_top
   import fbcsb_pkg::*;
;
   logic              clk = 1'b0;
   logic              reset_n = 1'b0;
   logic              frame_tick = 1'b0;
   logic [1:0]        com_phase = 2'h0;
   logic              scan_valid = 1'b0;
   fbcsb_scan_s       scan_req = '0;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic              reg_wr;
   logic              reg_rd;
   logic [DATA_W-1:0] reg_rdata;
   fbcsb_glyph_s      glyph;
   logic [SEG_OUTS-1:0] cols;
   int                n_mismatch = 0;
   int                total_checks = 0;
   logic [31:0]       seed = 32'h23AD57F8;
   logic [DATA_W-1:0] rq[$];
   fbcsb_glyph_s      gq[$];
   logic [DATA_W-1:0] er;
   fbcsb_glyph_s      eg;
   logic              rd_d = 1'b0;
   logic [7:0]        codes[16];
   logic [7:0]        fix[4] = '{8'h00, 8'h81, 8'h1F, 8'hFF};
   logic [6:0]        cp[4] = '{7'h13, 7'h20, 7'h00, 7'h34};
   logic [3:0]        hit = 4'h5;
   logic [3:0]        ra[5] = '{4'h0, 4'h1, 4'h5, 4'h4, 4'hF};

   always #4 clk = ~clk;

   fbcsb_top i_fbcsb_top (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .frame_tick(frame_tick), .com_phase(com_phase), .scan_valid(scan_valid),
      .scan_req(scan_req), .glyph(glyph), .column_driver_output(cols));
   fbcsb_host_model i_fbcsb_host_model (.clk(clk), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction

   function automatic fbcsb_glyph_s gx(input logic pg, input logic [7:0] cd,
                                       input logic [2:0] r, input logic [2:0] att);
      fbcsb_glyph_s g;
      g = GLYPH_RESET;
      g.valid = 1'b1;
      g.row = r;
      {g.reverse, g.underline, g.blank} = att;
      g.from_ram = pg ? (cd[6:5] == 2'h0) : (cd < 8'h10);
      if (g.from_ram) g.ram_dots = cd[0] ? 5'h0E : 5'h11;
      else if (!pg) g.rom_index = {1'b0, cd} - 9'h00F;
      else if (!cd[7]) g.rom_index = {1'b0, cd} - 9'h020 + 9'h0F1;
      else g.rom_index = {1'b0, cd} - 9'h0A0 + 9'h151;
      return g;
   endfunction

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      scan_valid <= 1'b0;
      i_fbcsb_host_model.xfer(1'b1, 1'b0, a, d);
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      rq.push_back(e);
      scan_valid <= 1'b0;
      i_fbcsb_host_model.xfer(1'b0, 1'b1, a, 16'h0000);
   endtask
   task automatic idle(input int n);
      scan_valid <= 1'b0;
      frame_tick <= 1'b0;
      repeat (n) i_fbcsb_host_model.xfer(1'b0, 1'b0, 4'h0, 16'h0000);
   endtask
   task automatic tick();
      frame_tick <= 1'b1;
      i_fbcsb_host_model.xfer(1'b0, 1'b0, 4'h0, 16'h0000);
      idle(1);
   endtask
   task automatic scan(input logic ln, input logic [3:0] col, input logic [2:0] r,
                       input fbcsb_glyph_s e);
      gq.push_back(e);
      scan_valid <= 1'b1;
      scan_req   <= '{line: ln, col: col, row: r};
      i_fbcsb_host_model.xfer(1'b0, 1'b0, 4'h0, 16'h0000);
   endtask
   task automatic conclude();
      $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Answers compared against the oldest note
   always @(posedge clk) begin
      rd_d <= reg_rd;
      if (rd_d) begin
         er = (rq.size() != 0) ? rq.pop_front() : ~reg_rdata;
         `CHK(reg_rdata, er)
      end
      if (glyph.valid === 1'b1) begin
         eg = (gq.size() != 0) ? gq.pop_front() : ~glyph;
         `CHK(glyph, eg)
      end
   end

   // Main sequence
   initial begin
      fbcsb_ctrl_s c;
      int          n;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      idle(2);
      foreach (ra[i]) rd(ra[i], 16'h0000);
      wr(REG_UFONT, 16'h0011);
      wr(REG_UFONT, 16'h080E);
      wr(REG_WPTR, 16'h0000);
      for (int i = 0; i < 16; i++) begin
         seed = xs(seed);
         codes[i] = (i < 4) ? fix[i] : seed[7:0];
         wr(REG_TEXT, {8'h00, codes[i]});
      end
      rd(REG_WPTR, 16'h0010);
      for (int p = 0; p < 2; p++) begin
         c = '{rom_page: p[0], default: 1'b0};
         i_fbcsb_host_model.set_ctrl(c);
         rd(REG_CTRL, 16'(c));
         for (int i = 0; i < 16; i++) scan(1'b0, 4'(i), 3'h0, gx(p[0], codes[i], 3'h0, 3'h0));
         idle(1);
      end
      // Row cursor selection by pointer
      c = '{row_highlight: 1'b1, reverse: 1'b1, underline: 1'b1,
            character_display_mode: 1'b1, default: 1'b0};
      i_fbcsb_host_model.set_ctrl(c);
      foreach (cp[i]) begin
         wr(REG_WPTR, {9'h000, cp[i]});
         scan(1'b0, 4'h0, 3'h0, gx(1'b0, 8'h00, 3'h0, {hit[i], hit[i], 1'b0}));
      end
      wr(REG_WPTR, 16'h0020);
      wr(REG_TEXT, 16'h0041);
      scan(1'b1, 4'h0, 3'h0, gx(1'b0, 8'h41, 3'h0, 3'h6));
      wr(REG_WPTR, 16'h0014);
      c.first_line_tall = 1'b1;
      i_fbcsb_host_model.set_ctrl(c);
      scan(1'b1, 4'h3, 3'h5, gx(1'b0, codes[3], 3'h6, 3'h0));
      // Blink period, sync and refused instruction
      // long period exercised
      for (int b = 0; b < 2; b++) begin
         idle(1);
         c = '{row_highlight: 1'b1, flash: 1'b1, flash_period_long: b[0],
               character_display_mode: 1'b1, default: 1'b0};
         i_fbcsb_host_model.set_ctrl(c);
         wr(REG_WPTR, 16'h0000);
         wr(REG_INSTR, {8'h00, INSTR_BLINK_SYNC});
         rd(REG_STATUS, 16'h0040);
         n = b ? FRAMES_LONG : FRAMES_SHORT;
         repeat (n - 1) tick();
         rd(REG_STATUS, 16'h0040 | 16'(n - 1));
         tick();
         wr(REG_INSTR, 16'h0071);
         rd(REG_STATUS, 16'h0000);
         scan(1'b0, 4'h0, 3'h0, gx(1'b0, 8'h00, 3'h0, 3'h1));
      end
      // Segment decode, one-bit then two-bit
      idle(1);
      i_fbcsb_host_model.set_ctrl(CTRL_RESET);
      wr(REG_WPTR, 16'h0000);
      wr(REG_TEXT, 16'h00A5);
      idle(30);
      `CHK(cols[7:0], 8'h15)
      i_fbcsb_host_model.set_ctrl('{two_bit_seg_mode: 1'b1, default: 1'b0});
      wr(REG_WPTR, 16'h0000);
      wr(REG_TEXT, 16'h001B);
      wr(REG_INSTR, 16'h0070);
      idle(30);
      `CHK(cols[3:0], 4'hA)
      repeat (FRAMES_SHORT) tick();
      idle(30);
      `CHK(cols[3:0], 4'hC)
      i_fbcsb_host_model.set_ctrl('{character_display_mode: 1'b1, default: 1'b0});
      com_phase <= 2'h2;
      idle(40);
      `CHK(cols, {SEG_OUTS{1'b0}})
      // Pointer decrement wraps below zero
      i_fbcsb_host_model.set_ctrl('{ptr_decrement: 1'b1, default: 1'b0});
      wr(REG_WPTR, 16'h0000);
      rd(REG_WPTR, 16'h0000);
      wr(REG_TEXT, 16'h0000);
      rd(REG_WPTR, 16'h004F);
      for (int k = 0; k < 50 && (rq.size() != 0 || gq.size() != 0); k++) idle(1);
      if (rq.size() != 0 || gq.size() != 0) n_mismatch++;
      conclude();
   end
endmodule
